// ===== logic/adc_seq_defines.svh
// constants of the conversion sequence controller: widths, counts and timing
// assumes a 40 MHz system clock that the end pulse count EOC_CYC is derived from
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ****************************************************************
// widths and sizes
// ****************************************************************
`define NUM_CH      4
`define DATA_W      12
`define FIFO_DEPTH  8

// ****************************************************************
// timing
// ****************************************************************
`define CLK_NS      25
`define EOC_NS      75
`define EOC_CYC     ((`EOC_NS + `CLK_NS - 1) / `CLK_NS)
`define CONV_CLKS   14
`define INT_DIV     5

// ****************************************************************
// reset values
// ****************************************************************
`define CHAN_SEL_RST 4'h0

`endif

// ===== logic/adc_seq_pkg.sv
// types of the conversion sequence controller
// assumes adc_seq_defines.svh is on the include path
`include "adc_seq_defines.svh"

package adc_seq_pkg;

    // ****************************************************************
    // sequencer states and the whole state of the controller
    // ****************************************************************
    typedef enum logic [2:0] {
        IDLE,
        SCAN,
        CONV,
        PUSH,
        EOC
    } seq_state_t;

    typedef struct packed {
        seq_state_t                          st;
        logic                                startPrev;
        logic                                wrPrev;
        logic                                rdPrev;
        logic                                extPrev;
        logic [`NUM_CH-1:0]                  chanSelReg;
        logic [`NUM_CH-1:0]                  seqMask;
        logic [1:0]                          curCh;
        logic [3:0]                          bitCnt;
        logic [2:0]                          divCnt;
        logic [2:0]                          eocCnt;
        logic [2:0]                          rdPtr;
        logic [`NUM_CH-1:0][`DATA_W-1:0]     held;
        logic                                busy;
        logic                                eocN;
        logic                                first;
        logic                                hold;
        logic                                oeN;
        logic [`DATA_W-1:0]                  dout;
    } ctrl_state_t;

endpackage

// ===== logic/sample_fifo.sv
// result buffer between the sequencer and the host read port
// assumes one clock and a synchronous active-high reset; flush empties it
`timescale 1ns/10ps

module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t f_q;
    fifo_state_t f_d;
    logic        doWr;
    logic        doRd;

    // ****************************************************************
    // handshakes and storage
    // ****************************************************************
    assign inReady  = (f_q.count != (AW+1)'(DEPTH));
    assign outValid = (f_q.count != '0);
    assign outData  = f_q.mem[f_q.rdPtr];   // read data straight from the storage register
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // pointers wrap by width, so depth must be a power of two
    always_comb begin
        f_d = f_q;
        if (doWr) begin
            f_d.mem[f_q.wrPtr] = inData;
            f_d.wrPtr          = f_q.wrPtr + 1'b1;
        end
        if (doRd) begin
            f_d.rdPtr = f_q.rdPtr + 1'b1;
        end
        f_d.count = f_q.count + (AW+1)'(doWr) - (AW+1)'(doRd);
        if (flush) begin
            f_d.wrPtr = '0;
            f_d.rdPtr = '0;
            f_d.count = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

endmodule // sample_fifo

// ===== logic/simultaneous_adc_sequence_ctrl.sv
// conversion control and parallel host port of a four-channel sampling converter
// assumes every pin input is synchronous to clk; held sample words come from the analog side
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module simultaneous_adc_sequence_ctrl
    import adc_seq_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              sampleStartN,
    input  wire logic                              csN,
    input  wire logic                              rdN,
    input  wire logic                              wrN,
    input  wire logic [`NUM_CH-1:0]                lowDataLinesIn,
    input  wire logic [`NUM_CH-1:0]                hwChannelPick,
    input  wire logic                              hwSwPick,
    input  wire logic                              clockSourcePick,
    input  wire logic                              extConvClock,
    input  wire logic                              powerSaveN,
    input  wire logic [`NUM_CH-1:0][`DATA_W-1:0]   analogSample,
    output logic                                   busy,
    output logic                                   eocN,
    output logic                                   firstResultFlag,
    output logic                                   holdAll,
    output logic [`DATA_W-1:0]                     dataOut,
    output logic                                   dataOeN
);

    ctrl_state_t        s_q;
    ctrl_state_t        s_d;
    logic               startRise;
    logic               wrRise;
    logic               rdRise;
    logic               convEn;
    logic               startOk;
    logic               fifoInValid;
    logic               fifoInReady;
    logic               fifoOutValid;
    logic               fifoOutReady;
    logic [`DATA_W-1:0] fifoOutData;

    // ****************************************************************
    // strobe edges and conversion clock enable
    // ****************************************************************
    assign startRise = sampleStartN && !s_q.startPrev;
    assign wrRise    = wrN && !s_q.wrPrev;
    assign rdRise    = rdN && !s_q.rdPrev;
    assign startOk   = startRise && (s_q.st == IDLE) && powerSaveN;
    // external clock edges are sampled, so it must run well below clk/2
    assign convEn    = powerSaveN && (clockSourcePick ? (extConvClock && !s_q.extPrev)
                                                      : (s_q.divCnt == 3'(`INT_DIV - 1)));

    // a read completes on the read strobe rising with select still low
    assign fifoOutReady = rdRise && !csN;
    assign fifoInValid  = (s_q.st == PUSH);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [1:0] nextCh;
        logic       found;
        nextCh = 2'h0;
        found  = 1'b0;
        s_d = s_q;
        s_d.startPrev = sampleStartN;
        s_d.wrPrev    = wrN;
        s_d.rdPrev    = rdN;
        s_d.extPrev   = extConvClock;
        s_d.eocN      = 1'b1;

        // internal oscillator divider; stopped in power save to save its toggling
        if (!powerSaveN || s_q.divCnt == 3'(`INT_DIV - 1)) begin
            s_d.divCnt = 3'h0;
        end else begin
            s_d.divCnt = s_q.divCnt + 3'h1;
        end

        // channel select register write; the host keeps rd high here
        if (wrRise && !csN && rdN) begin
            s_d.chanSelReg = lowDataLinesIn;
        end

        // lowest remaining channel first gives ascending order
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
            if (s_q.seqMask[i]) begin
                nextCh = 2'(i);
                found  = 1'b1;
            end
        end

        unique case (s_q.st)
            IDLE: begin
                if (startOk) begin
                    s_d.seqMask = hwSwPick ? s_q.chanSelReg : hwChannelPick;
                    s_d.held    = analogSample;
                    s_d.hold    = 1'b1;
                    s_d.busy    = 1'b1;
                    s_d.rdPtr   = 3'h0;
                    s_d.st      = SCAN;
                end
            end
            SCAN: begin
                if (found) begin
                    s_d.curCh           = nextCh;
                    s_d.seqMask[nextCh] = 1'b0;
                    s_d.bitCnt          = 4'h0;
                    s_d.st              = CONV;
                end else begin
                    s_d.busy = 1'b0;
                    s_d.hold = 1'b0;
                    s_d.st   = IDLE;
                end
            end
            CONV: begin
                if (convEn) begin
                    if (s_q.bitCnt == 4'(`CONV_CLKS - 1)) begin
                        s_d.st = PUSH;
                    end else begin
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end
                end
            end
            PUSH: begin
                // a full buffer stalls the sequence until the host reads
                if (fifoInReady) begin
                    s_d.eocN   = 1'b0;
                    s_d.eocCnt = 3'h1;
                    s_d.st     = EOC;
                    if (s_q.seqMask == '0) begin
                        s_d.busy = 1'b0;
                        s_d.hold = 1'b0;
                    end
                end
            end
            EOC: begin
                if (s_q.eocCnt == 3'(`EOC_CYC)) begin
                    s_d.st = SCAN;
                end else begin
                    s_d.eocN   = 1'b0;
                    s_d.eocCnt = s_q.eocCnt + 3'h1;
                end
            end
        endcase

        // output data register pointer advances once per completed read
        if (fifoOutReady && fifoOutValid && !startOk) begin
            s_d.rdPtr = s_q.rdPtr + 3'h1;
        end
        s_d.first = (s_d.rdPtr == 3'h0);
        s_d.oeN   = !(!csN && !rdN);
        s_d.dout  = fifoOutValid ? fifoOutData : '0;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q            <= '0;
            s_q.st         <= IDLE;
            s_q.startPrev  <= 1'b1;
            s_q.wrPrev     <= 1'b1;
            s_q.rdPrev     <= 1'b1;
            s_q.chanSelReg <= `CHAN_SEL_RST;
            s_q.eocN       <= 1'b1;
            s_q.first      <= 1'b1;
            s_q.oeN        <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy            = s_q.busy;
    assign eocN            = s_q.eocN;
    assign firstResultFlag = s_q.first;
    assign holdAll         = s_q.hold;
    assign dataOut         = s_q.dout;
    assign dataOeN         = s_q.oeN;

    // ****************************************************************
    // result buffer; cleared at each accepted start
    // ****************************************************************
    sample_fifo #(
        .WIDTH (`DATA_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .flush    (startOk),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (s_q.held[s_q.curCh]),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_busyRise;
        startOk |=> busy && holdAll;
    endproperty
    a_busyRise: assert property (p_busyRise) else $error("busy not raised on start");

    property p_busyFall;
        $fell(busy) |-> (s_q.seqMask == '0) && !holdAll;
    endproperty
    a_busyFall: assert property (p_busyFall) else $error("busy fell early");

    property p_first;
        firstResultFlag == (s_q.rdPtr == 3'h0);
    endproperty
    a_first: assert property (p_first) else $error("first flag wrong");

    property p_capture;
        startOk |=> s_q.seqMask == $past(hwSwPick ? s_q.chanSelReg : hwChannelPick)
                    && s_q.held == $past(analogSample);
    endproperty
    a_capture: assert property (p_capture) else $error("selection not captured");

    property p_oe;
        (!csN && !rdN) |=> !dataOeN;
    endproperty
    a_oe: assert property (p_oe) else $error("data not driven");

    property p_oeOff;
        (csN || rdN) |=> dataOeN;
    endproperty
    a_oeOff: assert property (p_oeOff) else $error("data driven outside read");

    property p_write;
        (wrRise && !csN && rdN) |=> s_q.chanSelReg == $past(lowDataLinesIn);
    endproperty
    a_write: assert property (p_write) else $error("select register not written");

    property p_csGate;
        (csN && !startOk) |=> $stable(s_q.chanSelReg) && $stable(s_q.rdPtr);
    endproperty
    a_csGate: assert property (p_csGate) else $error("access while deselected");

    property p_convLen;
        (s_q.st == CONV && convEn && s_q.bitCnt == 4'(`CONV_CLKS - 1)) |=> s_q.st == PUSH;
    endproperty
    a_convLen: assert property (p_convLen) else $error("conversion length wrong");

    property p_eoc;
        (s_q.st == PUSH && fifoInReady) |=> !eocN [*3] ##1 eocN;
    endproperty
    a_eoc: assert property (p_eoc) else $error("end pulse width wrong");

    property p_ptrReset;
        startOk |=> (s_q.rdPtr == 3'h0) && firstResultFlag;
    endproperty
    a_ptrReset: assert property (p_ptrReset) else $error("pointer not reset");

    c_fullSeq: cover property (startOk ##[1:1000] $fell(busy));
    c_read:    cover property (fifoOutReady && fifoOutValid);
    c_write:   cover property (wrRise && !csN && rdN);
    c_stall:   cover property (s_q.st == PUSH && !fifoInReady);

endmodule // simultaneous_adc_sequence_ctrl

// ===== tb/host_bus_model.sv
// host side of the parallel port: chip select, read and write strobes, low data lines
// assumes the bench calls its tasks; every change lands on a falling clock edge
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module host_bus_model (
    input  wire logic               clk,
    output logic                    csN,
    output logic                    rdN,
    output logic                    wrN,
    output logic [`NUM_CH-1:0]      lowDataLinesIn,
    input  wire logic [`DATA_W-1:0] dataOut,
    input  wire logic               dataOeN
);
    // ****************************************
    // bus level as the host sees it
    // ****************************************
    logic [`DATA_W-1:0] busLast;
    logic [`DATA_W-1:0] busLevel;

    // a released bus shows the inverse of the last word, so stale data never reads as valid
    always_ff @(posedge clk) begin
        if (!dataOeN) begin
            busLast <= dataOut;
        end
    end
    assign busLevel = dataOeN ? ~busLast : dataOut;

    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        lowDataLinesIn = 4'h0;
    end

    // ****************************************
    // bus cycles
    // ****************************************
    // select register write; lines held stable across the rising strobe
    task automatic write_sel(input logic [`NUM_CH-1:0] val);
        @(negedge clk);
        csN = 1'b0;
        rdN = 1'b1;
        lowDataLinesIn = val;
        @(negedge clk);
        wrN = 1'b0;
        @(negedge clk);
        wrN = 1'b1;
        @(negedge clk);
        csN = 1'b1;
        lowDataLinesIn = ~val;              // released lines no longer show the value
    endtask

    // read with chip select on or off; strobe held two clocks so the word is settled
    task automatic read_word(input logic sel, output logic [`DATA_W-1:0] word,
                             output logic oeSeen);
        @(negedge clk);
        csN = !sel;
        wrN = 1'b1;
        rdN = 1'b0;
        repeat (2) @(negedge clk);
        word = busLevel;
        oeSeen = dataOeN;
        rdN = 1'b1;
        @(negedge clk);
        csN = 1'b1;
        @(negedge clk);
    endtask
endmodule // host_bus_model

// ===== tb/simultaneous_adc_sequence_ctrl_test.sv
// self-checking bench of the conversion sequence controller
// assumes the design package and defines header are compiled first
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module simultaneous_adc_sequence_ctrl_test
    import adc_seq_pkg::*;
;
    logic                            clk;
    logic                            rst;
    logic                            sampleStartN;
    logic                            csN;
    logic                            rdN;
    logic                            wrN;
    logic [`NUM_CH-1:0]              lowDataLinesIn;
    logic [`NUM_CH-1:0]              hwChannelPick;
    logic                            hwSwPick;
    logic                            clockSourcePick;
    logic                            extConvClock;
    logic                            powerSaveN;
    logic [`NUM_CH-1:0][`DATA_W-1:0] analogSample;
    logic                            busy;
    logic                            eocN;
    logic                            firstResultFlag;
    logic                            holdAll;
    logic [`DATA_W-1:0]              dataOut;
    logic                            dataOeN;
    int                              mismatches;
    int                              testsRun;
    int                              eocCnt;
    int                              cycleCount;

    simultaneous_adc_sequence_ctrl i_simultaneous_adc_sequence_ctrl (
        .clk(clk), .rst(rst), .sampleStartN(sampleStartN), .csN(csN), .rdN(rdN), .wrN(wrN),
        .lowDataLinesIn(lowDataLinesIn), .hwChannelPick(hwChannelPick), .hwSwPick(hwSwPick),
        .clockSourcePick(clockSourcePick), .extConvClock(extConvClock),
        .powerSaveN(powerSaveN), .analogSample(analogSample), .busy(busy), .eocN(eocN),
        .firstResultFlag(firstResultFlag), .holdAll(holdAll), .dataOut(dataOut),
        .dataOeN(dataOeN));

    host_bus_model i_host_bus_model (
        .clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN), .lowDataLinesIn(lowDataLinesIn),
        .dataOut(dataOut), .dataOeN(dataOeN));

    // ****************************************
    // clocks, end pulse counter and hang guard
    // ****************************************
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // external conversion clock of eight system clocks, offset so its phase is unrelated
    initial extConvClock = 1'b0;
    always begin
        repeat (4) @(posedge clk);
        #3 extConvClock = ~extConvClock;
    end

    always @(posedge clk) begin
        if (eocN === 1'b0) begin
            eocCnt++;
        end
    end

    // whole run is about 500 cycles; the ceiling leaves a wide margin
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ****************************************
    // comparison and verdict
    // ****************************************
    task automatic check(input string what, input logic [`DATA_W-1:0] exp,
                         input logic [`DATA_W-1:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one sequence: start edge, busy span within lo..hi, end pulses, then read back
    // midWrite rewrites the selection while busy, which must not alter this sequence
    task automatic run_seq(input logic [`NUM_CH-1:0] mask, input int lo, input int hi,
                           input logic midWrite);
        int busyLen;
        int n;
        logic [`DATA_W-1:0] word;
        logic oe;
        busyLen = 0;
        n = 0;
        @(negedge clk);
        sampleStartN = 1'b0;
        @(negedge clk);
        sampleStartN = 1'b1;
        eocCnt = 0;
        repeat (2) @(negedge clk);
        check("busy after start", 1, busy);
        check("hold after start", 1, holdAll);
        fork
            while (busy === 1'b1 && busyLen < 2000) begin
                check("hold while busy", 1, holdAll);
                busyLen++;
                @(negedge clk);
            end
            if (midWrite) begin
                i_host_bus_model.write_sel(4'hF);
                hwChannelPick = 4'hF;
            end
        join
        check("busy span", 1, busyLen >= lo && busyLen <= hi);
        repeat (6) @(negedge clk);
        check("end pulse cycles", 3 * $countones(mask), eocCnt);
        i_host_bus_model.read_word(1'b0, word, oe);
        check("enable without select", 1, oe);
        for (int ch = 0; ch < `NUM_CH; ch++) begin
            if (mask[ch]) begin
                check("first flag", n == 0, firstResultFlag);
                i_host_bus_model.read_word(1'b1, word, oe);
                check("enable during read", 0, oe);
                check("result word", analogSample[ch], word);
                n++;
            end
        end
        check("first flag after reads", 0, firstResultFlag);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        sampleStartN = 1'b1;
        hwChannelPick = 4'h0;
        hwSwPick = 1'b0;
        clockSourcePick = 1'b0;
        powerSaveN = 1'b1;
        analogSample = {12'hD04, 12'hC03, 12'hB02, 12'hA01};
        mismatches = 0;
        testsRun = 0;
        eocCnt = 0;
        cycleCount = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("busy at reset", 0, busy);
        check("end pulse at reset", 1, eocN);
        check("first flag at reset", 1, firstResultFlag);
        check("enable at reset", 1, dataOeN);
        // pins pick channels one, two and four on the internal clock
        hwChannelPick = 4'hB;
        run_seq(4'hB, 200, 245, 1'b0);
        // register picks channel three; pins say all four and are ignored
        i_host_bus_model.write_sel(4'h4);
        hwSwPick = 1'b1;
        hwChannelPick = 4'hF;
        run_seq(4'h4, 65, 78, 1'b1);
        // pins again, channel one, on the slower external clock
        hwSwPick = 1'b0;
        hwChannelPick = 4'h1;
        clockSourcePick = 1'b1;
        run_seq(4'h1, 104, 120, 1'b0);
        clockSourcePick = 1'b0;
        // power save: a start edge is ignored
        powerSaveN = 1'b0;
        @(negedge clk);
        sampleStartN = 1'b0;
        @(negedge clk);
        sampleStartN = 1'b1;
        repeat (3) @(negedge clk);
        check("busy in power save", 0, busy);
        check("hold in power save", 0, holdAll);
        powerSaveN = 1'b1;
        repeat (4) @(negedge clk);
        conclude();
    end
endmodule // simultaneous_adc_sequence_ctrl_test
